// >>> pkg/alm_pkg.sv
// constants for the eight-channel limit monitor and its serial register port
// assumes a 16-bit frame: address, write flag, data, msb first
// Summary of operation
// - channel below-limit flags sit at odd status bits, channel 7 at bit 15
// - channel above-limit flags sit at even status bits, channel 0 at bit 0
// - a flag reads one after a violation on that channel, else zero
// - status flags are read-only to the host and zero after reset
// - each channel has its own writable and readable lower threshold register
// - results below the lower threshold raise the alert
// - results above the per-channel upper threshold raise the alert
// - threshold and margin registers keep only bits eight down to zero
// - the nine stored bits form the top of a 12-bit compare value
// - lower threshold and margin values get three zero low bits
// - upper threshold value gets three one low bits
// - with alert_sticky low, the per-channel margin decides when an active alert is released
// - lower threshold fields reset to all zeros
// - upper threshold fields reset to all ones
// - margin fields reset to all ones
// - reading status clears it on the second serial clock of that frame
// - a pending conversion result is sent instead and status stays intact
// - new violations add flags until the host reads the status
// - flags of channels not built in always read zero
package alm_pkg;
  localparam int NUM_CH = 8;
  localparam int FIELD_W = 9;
  localparam int INT_W = 12;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 5;
  localparam int CMD_ADDR_LSB = 11;
  localparam int CMD_WRITE_BIT = 10;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CLEAR_EDGE_CNT = 5'h01;
  localparam logic [4:0] ADDR_STATUS = 5'h07;
  localparam logic [4:0] ADDR_LIMIT_BASE = 5'h08;
  localparam int REGS_PER_CH = 3;
  localparam int SEL_LOWER = 0;
  localparam int SEL_UPPER = 1;
  localparam int SEL_MARGIN = 2;
  localparam logic [8:0] LOWER_RESET = 9'h000;
  localparam logic [8:0] UPPER_RESET = 9'h1ff;
  localparam logic [8:0] MARGIN_RESET = 9'h1ff;
  localparam logic [2:0] LOWER_FILL = 3'h0;
  localparam logic [2:0] UPPER_FILL = 3'h7;
  localparam logic [2:0] MARGIN_FILL = 3'h0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  typedef enum logic {
    ALM_FR_IDLE = 1'b0,
    ALM_FR_ACTIVE = 1'b1
  } alm_frame_e;
endpackage

// >>> hw/alm_sync.sv
// two-stage synchroniser for asynchronous pins
// assumes nothing but clk and nrst; the first stage feeds only the second
`timescale 1ns/1ps
module alm_sync #(
  parameter int W = 3,
  // reset level per bit, set to each pin's idle level to avoid false edges
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins in and synchronised copy out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // alm_sync

// >>> hw/alm_monitor.sv
// limit monitor: thresholds, margins and alert flags behind a serial port
// assumes serial pins are asynchronous to clk and much slower than it;
// conversion results arrive on clk as a one-cycle strobe
`timescale 1ns/1ps
module alm_monitor #(
  parameter int CH_COUNT = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial register port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // conversion results
  input wire logic conv_valid,
  input wire logic [2:0] conv_channel,
  input wire logic [11:0] conv_result,
  // alert mode and output
  input wire logic alert_sticky,
  output logic alert
);
  localparam int N = alm_pkg::NUM_CH;

  logic sclk_s, cs_n_s, sdi_s;
  logic sclk_prev_q, cs_prev_q;
  logic rise, fall, cs_fall, cs_rise;
  alm_pkg::alm_frame_e state_q, state_d;
  logic [4:0] bitcnt_q, bitcnt_d, rdptr_q, rdptr_d;
  logic [15:0] shin_q, shin_d, shout_q, shout_d, snap_q, snap_d;
  logic [15:0] status_q, status_d, res_word_q, res_word_d;
  logic [15:0] set_vec, impl_bits, cmd;
  logic stat_frame_q, stat_frame_d, res_pend_q, res_pend_d;
  logic sdo_q, sdo_d, sdo_oe_q, sdo_oe_d, alert_q, alert_d, clr_now;
  logic [8:0] lower_q [N];
  logic [8:0] lower_d [N];
  logic [8:0] upper_q [N];
  logic [8:0] upper_d [N];
  logic [8:0] margin_q [N];
  logic [8:0] margin_d [N];
  logic [N-1:0] act_lo_q, act_lo_d, act_hi_q, act_hi_d;
  logic [N-1:0] hit_lo, hit_hi, rel_lo, rel_hi;

  // cs_n idles high: resetting its stages low would open a phantom frame
  alm_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({sclk, cs_n, sdi}),
    .sync_out({sclk_s, cs_n_s, sdi_s})
  );

  // edges are taken from the second stage against a held copy
  assign rise = sclk_s & ~sclk_prev_q;
  assign fall = ~sclk_s & sclk_prev_q;
  assign cs_fall = cs_prev_q & ~cs_n_s;
  assign cs_rise = ~cs_prev_q & cs_n_s;

  // per-channel compare against the widened internal values
  for (genvar i = 0; i < N; i++) begin : g_ch
    logic [11:0] lo_int, hi_int, mg_int;
    logic [12:0] lo_rel_pt, res_plus_mg;
    logic sel;
    assign lo_int = {lower_q[i], alm_pkg::LOWER_FILL};
    assign hi_int = {upper_q[i], alm_pkg::UPPER_FILL};
    assign mg_int = {margin_q[i], alm_pkg::MARGIN_FILL};
    assign lo_rel_pt = {1'b0, lo_int} + {1'b0, mg_int};
    assign res_plus_mg = {1'b0, conv_result} + {1'b0, mg_int};
    // unbuilt channels never raise anything
    assign sel = conv_valid && (conv_channel == 3'(i)) && (i < CH_COUNT);
    assign hit_lo[i] = sel && (conv_result < lo_int);
    assign hit_hi[i] = sel && (conv_result > hi_int);
    // released only once back inside by the full margin
    assign rel_lo[i] = sel && ({1'b0, conv_result} >= lo_rel_pt);
    assign rel_hi[i] = sel && (res_plus_mg <= {1'b0, hi_int});
    assign set_vec[2*i+1] = hit_lo[i];
    assign set_vec[2*i] = hit_hi[i];
    assign impl_bits[2*i+1] = (i < CH_COUNT);
    assign impl_bits[2*i] = (i < CH_COUNT);
  end

  function automatic logic [15:0] rd_word(input logic [4:0] a);
    logic [15:0] w;
    w = '0;
    if (a == alm_pkg::ADDR_STATUS) begin
      w = status_q & impl_bits;
    end
    for (int i = 0; i < N; i++) begin
      // upper bits stay zero
      if (a == 5'(alm_pkg::ADDR_LIMIT_BASE + alm_pkg::REGS_PER_CH * i
          + alm_pkg::SEL_LOWER)) begin
        w = {7'h00, lower_q[i]};
      end
      if (a == 5'(alm_pkg::ADDR_LIMIT_BASE + alm_pkg::REGS_PER_CH * i
          + alm_pkg::SEL_UPPER)) begin
        w = {7'h00, upper_q[i]};
      end
      if (a == 5'(alm_pkg::ADDR_LIMIT_BASE + alm_pkg::REGS_PER_CH * i
          + alm_pkg::SEL_MARGIN)) begin
        w = {7'h00, margin_q[i]};
      end
    end
    return w;
  endfunction

  assign cmd = shin_q;
  // second rising edge of a frame that carries the status word
  assign clr_now = (state_q == alm_pkg::ALM_FR_ACTIVE) && rise &&
      (bitcnt_q == alm_pkg::CLEAR_EDGE_CNT) && stat_frame_q;

  always_comb begin
    state_d = state_q;
    bitcnt_d = bitcnt_q;
    rdptr_d = rdptr_q;
    shin_d = shin_q;
    shout_d = shout_q;
    snap_d = snap_q;
    stat_frame_d = stat_frame_q;
    res_pend_d = res_pend_q;
    res_word_d = res_word_q;
    sdo_d = sdo_q;
    sdo_oe_d = sdo_oe_q;
    lower_d = lower_q;
    upper_d = upper_q;
    margin_d = margin_q;
    if (cs_fall) begin
      state_d = alm_pkg::ALM_FR_ACTIVE;
      bitcnt_d = '0;
      sdo_oe_d = 1'b1;
      if (res_pend_q) begin
        // a fresh result overrides the pending register read
        shout_d = res_word_q;
        res_pend_d = 1'b0;
        stat_frame_d = 1'b0;
      end else begin
        shout_d = rd_word(rdptr_q);
        stat_frame_d = (rdptr_q == alm_pkg::ADDR_STATUS);
      end
      snap_d = shout_d;
      sdo_d = shout_d[15];
    end else if (state_q == alm_pkg::ALM_FR_ACTIVE) begin
      if (cs_rise) begin
        state_d = alm_pkg::ALM_FR_IDLE;
        sdo_oe_d = 1'b0;
        // short frames are dropped whole; long ones keep their last 16 bits
        if (bitcnt_q == alm_pkg::FRAME_BITS) begin
          if (cmd[alm_pkg::CMD_WRITE_BIT]) begin
            for (int i = 0; i < N; i++) begin
              if (cmd[15:11] == 5'(alm_pkg::ADDR_LIMIT_BASE
                  + alm_pkg::REGS_PER_CH * i + alm_pkg::SEL_LOWER)) begin
                lower_d[i] = cmd[8:0];
              end
              if (cmd[15:11] == 5'(alm_pkg::ADDR_LIMIT_BASE
                  + alm_pkg::REGS_PER_CH * i + alm_pkg::SEL_UPPER)) begin
                upper_d[i] = cmd[8:0];
              end
              if (cmd[15:11] == 5'(alm_pkg::ADDR_LIMIT_BASE
                  + alm_pkg::REGS_PER_CH * i + alm_pkg::SEL_MARGIN)) begin
                margin_d[i] = cmd[8:0];
              end
            end
          end else begin
            rdptr_d = cmd[15:11];
          end
        end
      end else begin
        if (rise) begin
          shin_d = {shin_q[14:0], sdi_s};
          bitcnt_d = (bitcnt_q == alm_pkg::FRAME_BITS) ? bitcnt_q :
              5'(bitcnt_q + 5'h01);
        end
        // idle-high clock gives a leading fall that must not shift
        if (fall && (bitcnt_q != 5'h00)) begin
          shout_d = {shout_q[14:0], 1'b0};
          sdo_d = shout_q[14];
        end
      end
    end
    if (conv_valid) begin
      res_pend_d = 1'b1;
      res_word_d = {1'b0, conv_channel, conv_result};
    end
  end

  always_comb begin
    // new events win over the read clear in the same cycle
    status_d = (status_q & ~(clr_now ? snap_q : 16'h0000)) | set_vec;
    status_d = status_d & impl_bits;
    act_lo_d = act_lo_q;
    act_hi_d = act_hi_q;
    if (clr_now) begin
      act_lo_d = '0;
      act_hi_d = '0;
    end
    if (!alert_sticky) begin
      act_lo_d = act_lo_d & ~rel_lo;
      act_hi_d = act_hi_d & ~rel_hi;
    end
    act_lo_d = act_lo_d | hit_lo;
    act_hi_d = act_hi_d | hit_hi;
    alert_d = |{act_lo_d, act_hi_d};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      state_q <= alm_pkg::ALM_FR_IDLE;
      bitcnt_q <= '0;
      rdptr_q <= '0;
      shin_q <= '0;
      shout_q <= '0;
      snap_q <= '0;
      stat_frame_q <= 1'b0;
      res_pend_q <= 1'b0;
      res_word_q <= '0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      status_q <= alm_pkg::STATUS_RESET;
      act_lo_q <= '0;
      act_hi_q <= '0;
      alert_q <= 1'b0;
      for (int i = 0; i < N; i++) begin
        lower_q[i] <= alm_pkg::LOWER_RESET;
        upper_q[i] <= alm_pkg::UPPER_RESET;
        margin_q[i] <= alm_pkg::MARGIN_RESET;
      end
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
      state_q <= state_d;
      bitcnt_q <= bitcnt_d;
      rdptr_q <= rdptr_d;
      shin_q <= shin_d;
      shout_q <= shout_d;
      snap_q <= snap_d;
      stat_frame_q <= stat_frame_d;
      res_pend_q <= res_pend_d;
      res_word_q <= res_word_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
      status_q <= status_d;
      act_lo_q <= act_lo_d;
      act_hi_q <= act_hi_d;
      alert_q <= alert_d;
      lower_q <= lower_d;
      upper_q <= upper_d;
      margin_q <= margin_d;
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe = sdo_oe_q;
  assign alert = alert_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ch7_below_a: assert property (hit_lo[7] |=> status_q[15])
    else $error("channel 7 below flag not at bit 15");
  ch0_above_a: assert property (hit_hi[0] |=> status_q[0])
    else $error("channel 0 above flag not at bit 0");
  flag_cause_a: assert property ($rose(status_q[5]) |-> $past(hit_lo[2]))
    else $error("channel 2 below flag rose without a violation");
  status_hw_only_a: assert property (
    (status_q & ~$past(status_q) & ~$past(set_vec)) == 16'h0000)
    else $error("status bit set without a hardware event");
  unbuilt_zero_a: assert property ((status_q & ~impl_bits) == 16'h0000)
    else $error("flag set for a channel that is not built");
  reserved_zero_a: assert property (
    (rdptr_q != alm_pkg::ADDR_STATUS) |-> (rd_word(rdptr_q) >> 9) == 16'h0000)
    else $error("reserved limit register bits read nonzero");
  upper_fill_a: assert property (
    (conv_valid && conv_channel == 3'h0 && conv_result == 12'hfff &&
     upper_q[0] == 9'h1ff && !status_q[0]) |=> !status_q[0])
    else $error("full-scale result flagged against full upper limit");
  read_clear_a: assert property (
    (clr_now && set_vec == 16'h0000) |=> (status_q & $past(snap_q)) == 16'h0000)
    else $error("status not cleared on second clock of its frame");
  result_first_a: assert property (
    (cs_fall && res_pend_q) |=> !stat_frame_q ##1 !clr_now)
    else $error("status frame started while a result was pending");
  flags_hold_a: assert property ((status_q[5] && !clr_now) |=> status_q[5])
    else $error("below flag lost before a status read");
  margin_release_a: assert property (
    (act_lo_q[1] && rel_lo[1] && !alert_sticky && !hit_lo[1] &&
     !(|act_hi_q) && (act_lo_q == 8'h02)) |=> !alert)
    else $error("alert not released after return inside margin");
  alert_follow_a: assert property (
    (|set_vec) |=> alert)
    else $error("alert not raised after a violation");

  below_seen_c: cover property (hit_lo[3] ##[1:20] clr_now);
  result_wins_c: cover property (cs_fall && res_pend_q);
  release_c: cover property (alert ##1 !alert);
  write_seen_c: cover property (cs_rise && bitcnt_q == alm_pkg::FRAME_BITS);
endmodule // alm_monitor

// >>> testbench/alm_host.sv
// serial host model: 16-bit frames, mode 0 or mode 3, msb first
// assumes clk is the device's system clock; pins move on its falling edge
`timescale 1ns/1ps
module alm_host (
  // system clock
  input wire logic clk,
  // serial pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  // clock level between frames: 0 for mode 0, 1 for mode 3
  logic idle_hi;

  initial begin
    idle_hi = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // change the idle clock level only while no frame is open
  task automatic set_mode(input logic hi);
    @(negedge clk);
    idle_hi = hi;
    sclk = hi;
    repeat (8) @(negedge clk);
  endtask

  // half periods of 6 clk keep every edge clear of the 2-flop sync
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    @(negedge clk);
    cs_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      // in mode 3 the first fall is a leading edge that must not shift
      sclk = 1'b0;
      sdi = tx[i];
      repeat (6) @(negedge clk);
      sclk = 1'b1;
      rx[i] = sdo;
      repeat (6) @(negedge clk);
    end
    sclk = idle_hi;
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    // idle data line must not look like a held bit
    sdi = ~sdi;
    repeat (8) @(negedge clk);
  endtask
endmodule // alm_host

// >>> testbench/test_alm_monitor.sv
// testbench for the limit monitor: full and four-channel builds
// assumes alm_host drives the shared serial pins; one clock domain
`timescale 1ns/1ps
module test_alm_monitor;
  logic clk, nrst, sclk, cs_n, sdi, miso, sel_s;
  logic sdo_m, oe_m, sdo_s, oe_s, alert_m, alert_s;
  logic conv_valid, alert_sticky;
  logic [2:0] conv_channel;
  logic [11:0] conv_result;
  logic [15:0] rx;
  int num_errors = 0;
  int comparisons = 0;

  // a released line shows the inverse of its last bit
  assign miso = sel_s ? (oe_s ? sdo_s : ~sdo_s) : (oe_m ? sdo_m : ~sdo_m);

  alm_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(miso));
  alm_monitor dut (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo_m), .sdo_oe(oe_m), .conv_valid(conv_valid),
    .conv_channel(conv_channel), .conv_result(conv_result),
    .alert_sticky(alert_sticky), .alert(alert_m));
  // reduced build shares all inputs; only channels 0 to 3 exist
  alm_monitor #(.CH_COUNT(4)) dut_small (.clk(clk), .nrst(nrst),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_s), .sdo_oe(oe_s),
    .conv_valid(conv_valid), .conv_channel(conv_channel),
    .conv_result(conv_result), .alert_sticky(alert_sticky),
    .alert(alert_s));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic int la(input int c, input int s);
    return 8 + 3 * c + s;
  endfunction

  task automatic wr(input int a, input logic [15:0] d);
    host.frame({5'(a), 1'b1, d[9:0]}, rx);
  endtask

  // a read command selects the word of the following frame
  task automatic rd(input int a, output logic [15:0] v);
    host.frame({5'(a), 11'h000}, rx);
    host.frame(16'h0000, v);
  endtask

  task automatic conv(input int c, input logic [11:0] r);
    @(negedge clk);
    conv_valid = 1'b1;
    conv_channel = 3'(c);
    conv_result = r;
    @(negedge clk);
    conv_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic chk_al(input logic e);
    check({15'h0000, alert_m}, {15'h0000, e});
  endtask

  task automatic st_read(input logic [15:0] ecv, input logic [15:0] est);
    host.frame({alm_pkg::ADDR_STATUS, 11'h000}, rx);
    check(rx, ecv);
    host.frame(16'h0000, rx);
    check(rx, est);
  endtask

  task automatic test_reset();
    logic [15:0] v;
    check({14'h0000, oe_m, alert_m}, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      rd(la(c, 0), v);
      check(v, 16'h0000);
      rd(la(c, 1), v);
      check(v, 16'h01ff);
      rd(la(c, 2), v);
      check(v, 16'h01ff);
    end
    rd(7, v);
    check(v, 16'h0000);
    $display("test_reset done");
  endtask

  task automatic test_access();
    logic [15:0] v;
    wr(la(3, 0), 16'hffff);
    rd(la(3, 0), v);
    check(v, 16'h01ff);
    wr(la(3, 1), 16'hfea5);
    rd(la(3, 1), v);
    check(v, 16'h00a5);
    wr(7, 16'hffff);
    rd(7, v);
    check(v, 16'h0000);
    host.set_mode(1'b1);
    wr(la(4, 2), 16'h0123);
    rd(la(4, 2), v);
    check(v, 16'h0123);
    host.set_mode(1'b0);
    $display("test_access done");
  endtask

  task automatic test_limits();
    logic [15:0] v;
    wr(la(2, 0), 16'h0010);
    wr(la(5, 1), 16'h0020);
    conv(2, 12'h080);
    conv(5, 12'h107);
    conv(0, 12'hfff);
    chk_al(1'b0);
    conv(2, 12'h07f);
    chk_al(1'b1);
    conv(5, 12'h108);
    st_read(16'h5108, 16'h0420);
    chk_al(1'b0);
    rd(7, v);
    check(v, 16'h0000);
    $display("test_limits done");
  endtask

  task automatic test_margin();
    wr(la(1, 0), 16'h0020);
    wr(la(1, 2), 16'h0002);
    conv(1, 12'h0ff);
    chk_al(1'b1);
    conv(1, 12'h10f);
    chk_al(1'b1);
    conv(1, 12'h110);
    chk_al(1'b0);
    st_read(16'h1110, 16'h0008);
    alert_sticky = 1'b1;
    conv(1, 12'h0ff);
    conv(1, 12'h110);
    chk_al(1'b1);
    st_read(16'h1110, 16'h0008);
    chk_al(1'b0);
    alert_sticky = 1'b0;
    $display("test_margin done");
  endtask

  task automatic test_pending();
    logic [15:0] v;
    conv(2, 12'h000);
    host.frame({5'h07, 11'h000}, rx);
    check(rx, 16'h2000);
    conv(4, 12'h800);
    host.frame(16'h0000, rx);
    check(rx, 16'h4800);
    rd(7, v);
    check(v, 16'h0020);
    rd(7, v);
    check(v, 16'h0000);
    $display("test_pending done");
  endtask

  task automatic test_small();
    wr(la(0, 1), 16'h0000);
    wr(la(6, 0), 16'h0010);
    wr(la(7, 0), 16'h0010);
    conv(6, 12'h000);
    conv(7, 12'h000);
    conv(0, 12'h008);
    conv(2, 12'h001);
    st_read(16'h2001, 16'ha021);
    conv(6, 12'h000);
    check({15'h0000, alert_s}, 16'h0000);
    conv(2, 12'h001);
    check({15'h0000, alert_s}, 16'h0001);
    sel_s = 1'b1;
    st_read(16'h2001, 16'h0020);
    sel_s = 1'b0;
    check({15'h0000, alert_s}, 16'h0000);
    $display("test_small done");
  endtask

  initial begin
    nrst = 1'b0;
    sel_s = 1'b0;
    conv_valid = 1'b0;
    conv_channel = 3'h0;
    conv_result = 12'h000;
    alert_sticky = 1'b0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    test_reset();
    test_access();
    test_limits();
    test_margin();
    test_pending();
    test_small();
    end_of_test();
  end

  // tests need about 18k cycles; a hang ends the run at 60k
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule // test_alm_monitor
